// ---- pkg/sps_regs.svh ----
// register offsets, field positions, reset values and timing counts of the phase sequencer
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define SPS_CTRL_OFS 8'h00
`define SPS_PRINT_DIV_OFS 8'h04
`define SPS_SCAN_DIV_OFS 8'h08
`define SPS_FEED_TARGET_OFS 8'h0c
`define SPS_STATUS_OFS 8'h10
`define SPS_SCAN_TRAVEL_OFS 8'h14
`define SPS_PRINT_STEPS_OFS 8'h18

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define SPS_CTRL_PRINT_RUN 0
`define SPS_CTRL_SCAN_RUN 1
`define SPS_CTRL_MODE_LO 2
`define SPS_CTRL_MODE_HI 4
`define SPS_CTRL_PRINT_REV 5
`define SPS_CTRL_SCAN_REV 6
`define SPS_CTRL_RESET 32'h0000_0000

// ----------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------
`define SPS_STAT_PRINT_ACT 0
`define SPS_STAT_SCAN_ACT 1
`define SPS_STAT_SCAN_DONE 2
`define SPS_STAT_HALF 3
`define SPS_STAT_PRINT_PH_LO 8
`define SPS_STAT_SCAN_PH_LO 12

// ----------------------------------------------------------------------
// timing and travel
// ----------------------------------------------------------------------
`define SPS_CLK_HZ 250000000
`define SPS_PRINT_RATE_PPS 824
`define SPS_SCAN_RATE_PPS 579
`define SPS_PRINT_DIV (`SPS_CLK_HZ / `SPS_PRINT_RATE_PPS)
`define SPS_SCAN_DIV (`SPS_CLK_HZ / `SPS_SCAN_RATE_PPS)
`define SPS_STEP_TRAVEL_UM 65
`define SPS_FEED_FULL_HALF_UM (2 * `SPS_STEP_TRAVEL_UM)
`define SPS_FEED_HALF_HALF_UM (`SPS_STEP_TRAVEL_UM)

`endif

// ---- pkg/sps_pkg.sv ----
// types shared by the phase sequencer modules
package sps_pkg;

  // scan operating mode as written to the control register
  typedef enum logic [2:0] {
    SPS_MODE_STANDBY,
    SPS_MODE_STANDARD,
    SPS_MODE_FINE_PHOTO,
    SPS_MODE_SUPER_FINE,
    SPS_MODE_PHOTO_TEXT,
    SPS_MODE_PREFEED_EJECT
  } sps_scan_mode_e;

  // scan motor run state
  typedef enum logic [0:0] {
    SPS_SCAN_IDLE,
    SPS_SCAN_ACTIVE
  } sps_scan_state_e;

  // four phase outputs, {a, b, a_n, b_n}
  typedef logic [3:0] sps_phase_t;

endpackage

// ---- design/sps_step_timer.sv ----
// step rate divider: one tick every divisor clocks while enabled
module sps_step_timer
  import sps_pkg::*;
#(
  parameter int W = 24
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic enable,
  input wire logic [W-1:0] divisor,
  // output
  output logic tick
);

  logic [W-1:0] cnt;
  logic [W-1:0] last;

  // a divisor of zero behaves as one
  assign last = (divisor == '0) ? '0 : divisor - 1'b1;

  // count restarts whenever the motor is stopped
  always_ff @(posedge clk)
  begin
    if (rst || !enable)
    begin
      cnt <= '0;
      tick <= 1'b0;
    end
    else if (cnt >= last)
    begin
      cnt <= '0;
      tick <= 1'b1;
    end
    else
    begin
      cnt <= cnt + 1'b1;
      tick <= 1'b0;
    end
  end

endmodule

// ---- design/sps_phase_gen.sv ----
// four-phase excitation generator, 2-phase or 1-2 phase
module sps_phase_gen
  import sps_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic enable,
  input wire logic step,
  input wire logic half,
  input wire logic reverse,
  // phase outputs
  output sps_phase_t phases
);

  logic [2:0] idx;
  logic [2:0] next_idx;

  // pattern at each of the eight half-step positions
  function automatic sps_phase_t pattern(input logic [2:0] i);
    case (i)
      3'h0: pattern = 4'h8;
      3'h1: pattern = 4'hc;
      3'h2: pattern = 4'h4;
      3'h3: pattern = 4'h6;
      3'h4: pattern = 4'h2;
      3'h5: pattern = 4'h3;
      3'h6: pattern = 4'h1;
      default: pattern = 4'h9;
    endcase
  endfunction

  // full step keeps odd positions (two coils on), half step walks all eight
  assign next_idx = half ? (reverse ? idx - 3'h1 : idx + 3'h1)
                         : {(reverse ? idx[2:1] - 2'h1 : idx[2:1] + 2'h1), 1'b1};

  // position advances one step per tick; outputs off when stopped
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      idx <= 3'h1;
      phases <= 4'h0;
    end
    else
    begin
      if (enable && step)
      begin
        idx <= next_idx;
      end
      phases <= enable ? pattern(idx) : 4'h0;
    end
  end

endmodule

// ---- design/sps_top.sv ----
// stepping motor phase sequencer with AHB-Lite register slave
`include "sps_regs.svh"

// Contract
// - four print feed motor excitation outputs drive an external driver stage.
// - printing steps the print motor in 2-phase pattern at 824 pps.
// - all four print phases share the first phase's waveform, shifted in sequence.
// - scan supply enable is high while the scan motor runs; it drops one clock before the scan phases go off.
// - four scan feed motor step outputs drive an external driver.
// - scan coils energise two phases at a time, one or two in super-fine; each advance is one step, a half step in super-fine.
// - one scan step counts as 0.065 mm of document travel.
// - all four scan phases share the first phase's waveform, shifted in sequence.
// - standard fax scanning uses 2-phase at 579 pps.
// - fine or photo scanning uses 2-phase at 579 pps.
// - super-fine scanning uses 1-2 phase half-stepping at 579 pps.
// - photo-with-text scanning uses 2-phase at 579 pps.
// - document pre-feed or eject uses 2-phase at 579 pps.
// - standby holds every scan phase output inactive.
module sps_top
  import sps_pkg::*;
#(
  parameter int DIV_W = 24,
  parameter logic [23:0] PRINT_DIV_RESET = 24'(`SPS_PRINT_DIV),
  parameter logic [23:0] SCAN_DIV_RESET = 24'(`SPS_SCAN_DIV)
)
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // print feed motor phases
  output logic PRINT_PHASE_A,
  output logic PRINT_PHASE_B,
  output logic PRINT_PHASE_A_N,
  output logic PRINT_PHASE_B_N,
  // scan feed motor phases and coil supply
  output logic SCAN_PHASE_A,
  output logic SCAN_PHASE_B,
  output logic SCAN_PHASE_A_N,
  output logic SCAN_PHASE_B_N,
  output logic SCAN_SUPPLY_EN
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic [31:0] ctrl;
  logic [DIV_W-1:0] print_div;
  logic [DIV_W-1:0] scan_div;
  logic [15:0] feed_target;
  logic scan_done;
  logic [17:0] scan_travel;
  logic [31:0] print_steps;
  sps_scan_state_e scan_state;
  sps_scan_state_e next_scan_state;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic rd_wait;
  logic [7:0] rd_addr;
  logic [31:0] rdata;
  sps_phase_t print_phases;
  sps_phase_t scan_phases;
  logic print_tick;
  logic scan_tick;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  wire addr_take = HSEL && HTRANS[1] && HREADY;
  wire wr_ctrl = wr_pend && (wr_addr == `SPS_CTRL_OFS);
  wire wr_print_div = wr_pend && (wr_addr == `SPS_PRINT_DIV_OFS);
  wire wr_scan_div = wr_pend && (wr_addr == `SPS_SCAN_DIV_OFS);
  wire wr_feed = wr_pend && (wr_addr == `SPS_FEED_TARGET_OFS);
  wire wr_status = wr_pend && (wr_addr == `SPS_STATUS_OFS);

  // ----------------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------------
  wire [2:0] mode_bits = ctrl[`SPS_CTRL_MODE_HI:`SPS_CTRL_MODE_LO];
  wire mode_standby = (mode_bits == SPS_MODE_STANDBY) ||
                      (mode_bits > SPS_MODE_PREFEED_EJECT);
  // only super fine half-steps; the other scan modes use 2-phase
  wire scan_half = (mode_bits == SPS_MODE_SUPER_FINE);
  wire print_run = ctrl[`SPS_CTRL_PRINT_RUN];
  wire scan_req = ctrl[`SPS_CTRL_SCAN_RUN] && !mode_standby;
  wire scan_active = (scan_state == SPS_SCAN_ACTIVE);

  // ----------------------------------------------------------------------
  // feed distance
  // ----------------------------------------------------------------------
  // travel is kept in half micrometres so a half step adds a whole number
  wire [17:0] step_travel = scan_half ? 18'(`SPS_FEED_HALF_HALF_UM)
                                      : 18'(`SPS_FEED_FULL_HALF_UM);
  wire [17:0] travel_sum = scan_travel + step_travel;
  wire [17:0] target_half = {1'b0, feed_target, 1'b0};
  // stop on the tick after the feed is covered so the last step is held a full period
  wire feed_reached = scan_active && scan_tick && (feed_target != 16'h0) &&
                      (scan_travel >= target_half);
  // the stopping tick neither advances the pattern nor adds travel
  wire scan_step = scan_tick && !feed_reached;

  // ----------------------------------------------------------------------
  // scan run state
  // ----------------------------------------------------------------------
  // the scan motor runs while requested and stops when the feed is reached
  always_comb
  begin
    next_scan_state = scan_state;
    case (scan_state)
      SPS_SCAN_IDLE:
      begin
        if (scan_req)
        begin
          next_scan_state = SPS_SCAN_ACTIVE;
        end
      end
      SPS_SCAN_ACTIVE:
      begin
        if (!scan_req || feed_reached)
        begin
          next_scan_state = SPS_SCAN_IDLE;
        end
      end
      default:
      begin
        next_scan_state = SPS_SCAN_IDLE;
      end
    endcase
  end

  // scan state register
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      scan_state <= SPS_SCAN_IDLE;
    end
    else
    begin
      scan_state <= next_scan_state;
    end
  end

  // ----------------------------------------------------------------------
  // control and divider registers
  // ----------------------------------------------------------------------
  // a software write to control wins over the hardware clear of scan run
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      ctrl <= `SPS_CTRL_RESET;
    end
    else if (wr_ctrl)
    begin
      ctrl <= {25'h0, HWDATA[6:0]};
    end
    else if (feed_reached)
    begin
      ctrl[`SPS_CTRL_SCAN_RUN] <= 1'b0;
    end
  end

  // programmable step periods, reset to the documented rates
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      print_div <= DIV_W'(PRINT_DIV_RESET);
      scan_div <= DIV_W'(SCAN_DIV_RESET);
      feed_target <= 16'h0;
    end
    else
    begin
      if (wr_print_div)
      begin
        print_div <= HWDATA[DIV_W-1:0];
      end
      if (wr_scan_div)
      begin
        scan_div <= HWDATA[DIV_W-1:0];
      end
      if (wr_feed)
      begin
        feed_target <= HWDATA[15:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // travel, step count and done flag
  // ----------------------------------------------------------------------
  // travel restarts each time the scan motor starts; done set beats clear
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      scan_travel <= 18'h0;
      scan_done <= 1'b0;
    end
    else
    begin
      if (!scan_active && scan_req)
      begin
        scan_travel <= 18'h0;
      end
      else if (scan_active && scan_step)
      begin
        scan_travel <= travel_sum;
      end
      if (feed_reached)
      begin
        scan_done <= 1'b1;
      end
      else if (wr_status && HWDATA[`SPS_STAT_SCAN_DONE])
      begin
        scan_done <= 1'b0;
      end
    end
  end

  // print steps taken since reset
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      print_steps <= 32'h0;
    end
    else if (print_run && print_tick)
    begin
      print_steps <= print_steps + 32'h1;
    end
  end

  // ----------------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------------
  // read mux over the word address held from the address phase
  assign rdata = (rd_addr == `SPS_CTRL_OFS) ? ctrl :
                 (rd_addr == `SPS_PRINT_DIV_OFS) ? 32'(print_div) :
                 (rd_addr == `SPS_SCAN_DIV_OFS) ? 32'(scan_div) :
                 (rd_addr == `SPS_FEED_TARGET_OFS) ? {16'h0, feed_target} :
                 (rd_addr == `SPS_STATUS_OFS) ?
                   {16'h0, scan_phases, print_phases, 4'h0, scan_half, scan_done,
                    scan_active, print_run} :
                 (rd_addr == `SPS_SCAN_TRAVEL_OFS) ? {14'h0, scan_travel} :
                 (rd_addr == `SPS_PRINT_STEPS_OFS) ? print_steps :
                 32'h0;

  // reads add one wait state so a write just before is already stored
  assign HREADYOUT = !rd_wait;
  assign HRESP = 1'b0;

  // address phase capture and registered read data
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      rd_wait <= 1'b0;
      rd_addr <= 8'h00;
      HRDATA <= 32'h0;
    end
    else
    begin
      wr_pend <= addr_take && HWRITE;
      rd_wait <= addr_take && !HWRITE;
      if (addr_take)
      begin
        wr_addr <= (HADDR[31:8] == 24'h0) ? {HADDR[7:2], 2'b00} : 8'hff;
        rd_addr <= (HADDR[31:8] == 24'h0) ? {HADDR[7:2], 2'b00} : 8'hff;
      end
      if (rd_wait)
      begin
        HRDATA <= rdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // step timers
  // ----------------------------------------------------------------------
  sps_step_timer #(.W(DIV_W)) u_print_timer (
    .clk(CORE_CLK),
    .rst(RST),
    .enable(print_run),
    .divisor(print_div),
    .tick(print_tick)
  );

  sps_step_timer #(.W(DIV_W)) u_scan_timer (
    .clk(CORE_CLK),
    .rst(RST),
    .enable(scan_active),
    .divisor(scan_div),
    .tick(scan_tick)
  );

  // ----------------------------------------------------------------------
  // phase generators
  // ----------------------------------------------------------------------
  sps_phase_gen u_print_phase (
    .clk(CORE_CLK),
    .rst(RST),
    .enable(print_run),
    .step(print_tick),
    .half(1'b0),
    .reverse(ctrl[`SPS_CTRL_PRINT_REV]),
    .phases(print_phases)
  );

  sps_phase_gen u_scan_phase (
    .clk(CORE_CLK),
    .rst(RST),
    .enable(scan_active),
    .step(scan_step),
    .half(scan_half),
    .reverse(ctrl[`SPS_CTRL_SCAN_REV]),
    .phases(scan_phases)
  );

  // ----------------------------------------------------------------------
  // motor outputs
  // ----------------------------------------------------------------------
  // phases come straight from the generator flip-flops
  assign PRINT_PHASE_A = print_phases[3];
  assign PRINT_PHASE_B = print_phases[2];
  assign PRINT_PHASE_A_N = print_phases[1];
  assign PRINT_PHASE_B_N = print_phases[0];
  assign SCAN_PHASE_A = scan_phases[3];
  assign SCAN_PHASE_B = scan_phases[2];
  assign SCAN_PHASE_A_N = scan_phases[1];
  assign SCAN_PHASE_B_N = scan_phases[0];

  // coil supply follows the scan run state register
  assign SCAN_SUPPLY_EN = scan_active;

endmodule

// ---- verif/sps_props.sv ----
// concurrent checks on the phase sequencer ports
module sps_props
  import sps_pkg::*;
#(
  parameter int PDIV = 8
)
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // motors
  input wire logic PRINT_PHASE_A,
  input wire logic PRINT_PHASE_B,
  input wire logic PRINT_PHASE_A_N,
  input wire logic PRINT_PHASE_B_N,
  input wire logic SCAN_PHASE_A,
  input wire logic SCAN_PHASE_B,
  input wire logic SCAN_PHASE_A_N,
  input wire logic SCAN_PHASE_B_N,
  input wire logic SCAN_SUPPLY_EN
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // ------
  // helpers
  // ------
  wire sps_phase_t pr = {PRINT_PHASE_A, PRINT_PHASE_B, PRINT_PHASE_A_N, PRINT_PHASE_B_N};
  wire sps_phase_t sc = {SCAN_PHASE_A, SCAN_PHASE_B, SCAN_PHASE_A_N, SCAN_PHASE_B_N};
  wire take = HSEL && HTRANS[1] && HREADY;
  sps_phase_t pr_q;
  sps_phase_t sc_q;
  logic run_ok;
  int gap;
  wire chg = pr != pr_q;
  wire step = chg && pr != 4'h0 && pr_q != 4'h0;
  wire sc_step = sc != sc_q && sc != 4'h0 && sc_q != 4'h0;
  // cycles since the last print pattern change, valid once stepping is steady
  always_ff @(posedge CORE_CLK)
  begin
    pr_q <= pr;
    sc_q <= sc;
    gap <= chg ? 1 : gap + 1;
    run_ok <= (RST || pr == 4'h0) ? 1'b0 : (step ? 1'b1 : run_ok);
  end
  // ------
  // assertions
  // ------
  property p_rst_off;
    $fell(RST) |-> pr == 4'h0 && sc == 4'h0 && !SCAN_SUPPLY_EN;
  endproperty
  a_rst_off: assert property (p_rst_off) else $error("outputs live after reset");
  property p_pr_pair;
    pr != 4'h0 |-> $countones(pr) == 2;
  endproperty
  a_pr_pair: assert property (p_pr_pair) else $error("print not two coils");
  property p_pr_adj;
    step |-> $countones(pr & pr_q) == 1;
  endproperty
  a_pr_adj: assert property (p_pr_adj) else $error("print step not adjacent");
  property p_pr_rate;
    run_ok && step |-> gap == PDIV;
  endproperty
  a_pr_rate: assert property (p_pr_rate) else $error("print step period wrong");
  property p_sc_opp;
    !(SCAN_PHASE_A && SCAN_PHASE_A_N) && !(SCAN_PHASE_B && SCAN_PHASE_B_N);
  endproperty
  a_sc_opp: assert property (p_sc_opp) else $error("opposed scan coils on");
  property p_sc_move;
    sc_step |-> $countones(sc & sc_q) != 0 && $countones(sc ^ sc_q) <= 2;
  endproperty
  a_sc_move: assert property (p_sc_move) else $error("scan step not adjacent");
  property p_sc_supply;
    sc != 4'h0 |-> SCAN_SUPPLY_EN || $past(SCAN_SUPPLY_EN);
  endproperty
  a_sc_supply: assert property (p_sc_supply) else $error("scan coils without supply");
  property p_sc_idle;
    !SCAN_SUPPLY_EN && !$past(SCAN_SUPPLY_EN) |-> sc == 4'h0;
  endproperty
  a_sc_idle: assert property (p_sc_idle) else $error("scan coils on while idle");
  property p_rd_wait;
    take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  c_print: cover property (run_ok && step);
  c_half: cover property (sc != 4'h0 && $countones(sc) == 1);
  c_supply: cover property ($fell(SCAN_SUPPLY_EN));
endmodule

// ---- verif/sps_coil_model.sv ----
// driver stage and coil model: counts steps seen on four phase lines
module sps_coil_model
(
  input wire logic clk,
  input wire logic en,
  input wire logic [3:0] ph,
  input wire logic clr,
  output int steps,
  output logic single
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] prev = 4'h0;
  initial steps = 0;
  initial single = 1'b0;
  // a step is a move between two energised patterns while supplied
  always @(posedge clk)
  begin
    prev <= ph;
    if (clr)
    begin
      steps <= 0;
      single <= 1'b0;
    end
    else
    begin
      if (en && ph != prev && ph != 4'h0 && prev != 4'h0)
        steps <= steps + 1;
      if (ph != 4'h0 && $countones(ph) == 1)
        single <= 1'b1;
    end
  end
endmodule

// ---- verif/stepper_phase_sequencer_tb_top.sv ----
// testbench top for the phase sequencer
`include "sps_regs.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
  $display("ERROR %0t value mismatch", $time); end end
module stepper_phase_sequencer_tb_top
  import sps_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PDIV = 8;
  localparam int SDIV = 12;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic clr = 1'b0;
  logic [31:0] rd;
  wire logic [31:0] hrdata;
  wire logic hready, hresp, pa, pb, pan, pbn, sa, sb, san, sbn, sup, s1;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int ps, ss;
  sps_top #(.PRINT_DIV_RESET(24'(PDIV)), .SCAN_DIV_RESET(24'(SDIV))) i_sps_top (
    .CORE_CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .PRINT_PHASE_A(pa), .PRINT_PHASE_B(pb),
    .PRINT_PHASE_A_N(pan), .PRINT_PHASE_B_N(pbn), .SCAN_PHASE_A(sa), .SCAN_PHASE_B(sb),
    .SCAN_PHASE_A_N(san), .SCAN_PHASE_B_N(sbn), .SCAN_SUPPLY_EN(sup));
  sps_coil_model i_sps_coil_model (.clk(clk), .en(1'b1), .ph({pa, pb, pan, pbn}),
    .clr(clr), .steps(ps), .single());
  sps_coil_model i_sps_coil_model_scan (.clk(clk), .en(sup), .ph({sa, sb, san, sbn}),
    .clr(clr), .steps(ss), .single(s1));
  // clock and hang guard
  initial forever #2 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fail_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (fail_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // one AHB-Lite single transfer; read data lands in rd
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic clear_models();
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask
  task automatic t_reset();
    `CHK({pa, pb, pan, pbn, sa, sb, san, sbn, sup}, 9'h0)
    `CHK(hresp, 1'b0)
    ahb(1'b0, `SPS_CTRL_OFS, 32'h0);
    `CHK(rd, `SPS_CTRL_RESET)
    ahb(1'b0, `SPS_PRINT_DIV_OFS, 32'h0);
    `CHK(rd, 32'(PDIV))
    ahb(1'b1, 8'h40, 32'hffff_ffff);
    ahb(1'b0, 8'h40, 32'h0);
    `CHK(rd, 32'h0)
  endtask
  task automatic t_print();
    clear_models();
    ahb(1'b1, `SPS_CTRL_OFS, 32'h1);
    repeat (10 * PDIV) @(posedge clk);
    `CHK(ps inside {[8:11]}, 1'b1)
    `CHK($countones({pa, pb, pan, pbn}), 2)
    ahb(1'b1, `SPS_CTRL_OFS, 32'h0);
    repeat (2) @(posedge clk);
    `CHK({pa, pb, pan, pbn}, 4'h0)
  endtask
  // one feed in mode m: n steps expected, half tells whether single coils appear
  task automatic t_scan(input logic [2:0] m, input logic [15:0] um, input int n,
    input logic half);
    clear_models();
    ahb(1'b1, `SPS_FEED_TARGET_OFS, {16'h0, um});
    ahb(1'b1, `SPS_CTRL_OFS, {27'h0, m, 2'b10});
    repeat (3) @(posedge clk);
    `CHK(sup, m != 3'h0)
    repeat (4 * SDIV) @(posedge clk);
    `CHK(ss, n)
    `CHK(s1, half)
    `CHK({sup, sa, sb, san, sbn}, 5'h0)
    ahb(1'b0, `SPS_STATUS_OFS, 32'h0);
    `CHK(rd[`SPS_STAT_SCAN_DONE], m != 3'h0)
    ahb(1'b1, `SPS_STATUS_OFS, 32'h4);
  endtask
  task automatic t_div();
    clear_models();
    ahb(1'b1, `SPS_SCAN_DIV_OFS, 32'd20);
    ahb(1'b1, `SPS_FEED_TARGET_OFS, 32'h0);
    ahb(1'b1, `SPS_CTRL_OFS, {27'h0, SPS_MODE_STANDARD, 2'b10});
    repeat (200) @(posedge clk);
    `CHK(ss inside {[8:10]}, 1'b1)
    ahb(1'b1, `SPS_CTRL_OFS, 32'h0);
    repeat (3) @(posedge clk);
    `CHK({sup, sa, sb, san, sbn}, 5'h0)
  endtask
  // main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_print();
    t_scan(SPS_MODE_STANDBY, 16'd130, 0, 1'b0);
    t_scan(SPS_MODE_STANDARD, 16'd130, 2, 1'b0);
    t_scan(SPS_MODE_FINE_PHOTO, 16'd130, 2, 1'b0);
    t_scan(SPS_MODE_PHOTO_TEXT, 16'd130, 2, 1'b0);
    t_scan(SPS_MODE_PREFEED_EJECT, 16'd130, 2, 1'b0);
    t_scan(SPS_MODE_SUPER_FINE, 16'd65, 2, 1'b1);
    t_div();
    finish_test();
  end
endmodule
bind sps_top sps_props #(.PDIV(PRINT_DIV_RESET)) i_sps_props (
  .CORE_CLK(CORE_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PRINT_PHASE_A(PRINT_PHASE_A),
  .PRINT_PHASE_B(PRINT_PHASE_B), .PRINT_PHASE_A_N(PRINT_PHASE_A_N),
  .PRINT_PHASE_B_N(PRINT_PHASE_B_N), .SCAN_PHASE_A(SCAN_PHASE_A), .SCAN_PHASE_B(SCAN_PHASE_B),
  .SCAN_PHASE_A_N(SCAN_PHASE_A_N), .SCAN_PHASE_B_N(SCAN_PHASE_B_N),
  .SCAN_SUPPLY_EN(SCAN_SUPPLY_EN));
